/* File: rtl/led_i2c_pkg.sv */
// shared constants, register map and state types for the paged led driver serial link
package led_i2c_pkg;

  // timing of the host-made serial clock
  localparam int CLK_PERIOD_NS   = 20;
  localparam int SCL_PERIOD_NS   = 2500;
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // fixed upper slave address bits, value is arbitrary
  localparam logic [2:0] ADDR_FIXED_BITS = 3'h5;

  // register offsets
  localparam logic [7:0] REG_CFG         = 8'h00;
  localparam logic [7:0] REG_GCC         = 8'h01;
  localparam logic [7:0] REG_RES         = 8'h02;
  localparam logic [7:0] REG_TEMP        = 8'h24;
  localparam logic [7:0] REG_SPREAD      = 8'h25;
  localparam logic [7:0] REG_SOFT_RESET  = 8'h2f;
  localparam logic [7:0] REG_ID          = 8'hfc;
  localparam logic [7:0] REG_PAGE        = 8'hfd;
  localparam logic [7:0] REG_UNLOCK      = 8'hfe;
  localparam logic [7:0] REG_LED_FIRST   = 8'h01;
  localparam logic [7:0] REG_LED_LAST    = 8'hc6;
  localparam int         LED_COUNT       = 198;

  // page codes and unlock key
  localparam logic [7:0] PWM_PAGE        = 8'h00;
  localparam logic [7:0] SCALING_PAGE    = 8'h01;
  localparam logic [7:0] FUNCTION_PAGE   = 8'h02;
  localparam logic [7:0] UNLOCK_KEY      = 8'hc5;
  localparam logic [7:0] RES_RST         = 8'h33;

  // host command port offsets and fields
  localparam logic [3:0] HOST_CMD_OFS    = 4'h0;
  localparam logic [3:0] HOST_STAT_OFS   = 4'h4;
  localparam int         CMD_START_BIT   = 8;
  localparam int         CMD_STOP_BIT    = 9;
  localparam int         CMD_READ_BIT    = 10;
  localparam int         CMD_NACK_BIT    = 11;

  typedef struct packed {
    logic [7:0]                  page;
    logic [7:0]                  unlock;
    logic [7:0]                  cfg;
    logic [7:0]                  gcc;
    logic [7:0]                  res;
    logic [7:0]                  temp;
    logic [7:0]                  spread;
    logic [LED_COUNT-1:0][7:0]   pwm;
    logic [LED_COUNT-1:0][7:0]   scale;
  } regs_t;

  localparam regs_t REGS_RST = '{res: RES_RST, default: '0};

  typedef enum logic [4:0] {
    DS_IDLE = 5'b00001,
    DS_RX   = 5'b00010,
    DS_ACK  = 5'b00100,
    DS_TX   = 5'b01000,
    DS_MACK = 5'b10000
  } dev_state_t;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_START = 4'b0010,
    HS_BITS  = 4'b0100,
    HS_STOP  = 4'b1000
  } host_state_t;

  typedef struct packed {
    dev_state_t  st;
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [3:0]  strap_s1;
    logic [3:0]  strap_s2;
    logic [6:0]  own;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [1:0]  byte_no;
    logic        rd;
    logic        mack;
    logic [7:0]  ptr;
    logic        sda_oe_n;
    logic [7:0]  pwm_o;
    logic [7:0]  scale_o;
    regs_t       regs;
  } dev_t;

  localparam dev_t DEV_RST = '{st: DS_IDLE, scl_s: 3'h7, sda_s: 3'h7, sda_oe_n: 1'b1,
                               regs: REGS_RST, default: '0};

  typedef struct packed {
    host_state_t st;
    logic [7:0]  tick;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [8:0]  tx;
    logic [8:0]  rx;
    logic        stop_after;
    logic        is_read;
    logic        scl;
    logic        sda_oe_n;
    logic        sda_s1;
    logic        sda_s2;
    logic        acked;
    logic [7:0]  rx_byte;
    logic        rvalid;
    logic [31:0] rdata;
  } host_t;

  localparam host_t HOST_RST = '{st: HS_IDLE, scl: 1'b1, sda_oe_n: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                                 default: '0};

endpackage

/* File: rtl/i2c_link_if.sv */
// two-wire link between the host controller and the led driver
`timescale 1ns/10ps
interface i2c_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // open-drain wire with pull-up
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

/* File: rtl/led_i2c_device.sv */
// serial slave front end and paged register file of the led matrix driver
// Behaviour
// - 7-bit address plus direction bit, 1 reads
// - straps give address bits A1:A0 and A3:A2
// - data sampled while clock stably high
// - master keeps data high when idle
// - data falling with clock high starts
// - master sends address byte msb first
// - device pulls data low on address acknowledge
// - master stops on missing acknowledge
// - register address byte follows, acknowledged
// - data bytes msb first, each acknowledged
// - data rising with clock high stops
// - pointer increments during each data acknowledge
// - increment continues without burst limit
// - reads use repeated start after pointer write
// - master selects page before reading it
// - page codes pwm, scaling, function, rest reserved
// - page select locked after reset
// - key allows one page write, then relocks
// - page select starts at pwm page
// - identification returns own slave address
// - soft reset write restores all registers
// - writes land in currently selected page
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/10ps
module led_i2c_device
  import led_i2c_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  // serial link
  i2c_link_if.device      link,
  // address straps, 00 gnd, 01 clock line, 10 data line, 11 supply
  input  wire logic [1:0] addr_strap_low_i,
  input  wire logic [1:0] addr_strap_high_i,
  // led value read port
  input  wire logic [7:0] led_index_i,
  output logic      [7:0] pwm_duty_o,
  output logic      [7:0] current_scale_o,
  // page select and function page contents
  output logic      [7:0] page_o,
  output logic      [7:0] operating_config_o,
  output logic      [7:0] global_current_o,
  output logic      [7:0] resistor_select_o,
  output logic      [7:0] spread_spectrum_o
);

  dev_t q;
  dev_t d;

  // value returned for a register read in the current page
  function automatic logic [7:0] rd_byte(input regs_t r, input logic [7:0] p, input logic [6:0] own);
    logic [7:0] v;
    logic       led;
    v   = 8'h00;
    led = (p >= REG_LED_FIRST) && (p <= REG_LED_LAST);
    if (p == REG_ID) begin
      v = {own, 1'b0};
    end else if (p == REG_UNLOCK) begin
      v = r.unlock;
    end else if (p != REG_PAGE) begin
      case (r.page)
        PWM_PAGE: begin
          if (led) v = r.pwm[p - REG_LED_FIRST];
        end
        SCALING_PAGE: begin
          if (led) v = r.scale[p - REG_LED_FIRST];
        end
        FUNCTION_PAGE: begin
          case (p)
            REG_CFG:    v = r.cfg;
            REG_GCC:    v = r.gcc;
            REG_RES:    v = r.res;
            REG_TEMP:   v = r.temp;
            REG_SPREAD: v = r.spread;
            default:    v = 8'h00; // fault results and unused read as zero
          endcase
        end
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // effect of one written data byte on the register file
  function automatic regs_t wr_byte(input regs_t r, input logic [7:0] p, input logic [7:0] v);
    regs_t n;
    logic  led;
    n   = r;
    led = (p >= REG_LED_FIRST) && (p <= REG_LED_LAST);
    if (p == REG_UNLOCK) begin
      n.unlock = v;
    end else if (p == REG_PAGE) begin
      if (r.unlock == UNLOCK_KEY) begin
        n.page   = v;
        n.unlock = 8'h00;
      end
    end else if (p != REG_ID) begin
      case (r.page)
        PWM_PAGE: begin
          if (led) n.pwm[p - REG_LED_FIRST] = v;
        end
        SCALING_PAGE: begin
          if (led) n.scale[p - REG_LED_FIRST] = v;
        end
        FUNCTION_PAGE: begin
          case (p)
            REG_CFG:        n.cfg    = v;
            REG_GCC:        n.gcc    = v;
            REG_RES:        n.res    = v;
            REG_TEMP:       n.temp   = v;
            REG_SPREAD:     n.spread = v;
            REG_SOFT_RESET: n        = REGS_RST;
            default:        n        = r;
          endcase
        end
        default: n = r;
      endcase
    end
    return n;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic scl_high;
  logic start_seen;
  logic stop_seen;

  // edges from the second and third sync stages only
  assign scl_rise   = q.scl_s[1] & ~q.scl_s[2];
  assign scl_fall   = ~q.scl_s[1] & q.scl_s[2];
  assign scl_high   = q.scl_s[1] & q.scl_s[2];
  assign start_seen = scl_high & ~q.sda_s[1] & q.sda_s[2];
  assign stop_seen  = scl_high & q.sda_s[1] & ~q.sda_s[2];

  // next state
  always_comb begin
    d          = q;
    d.scl_s    = {q.scl_s[1:0], link.scl};
    d.sda_s    = {q.sda_s[1:0], link.sda};
    d.strap_s1 = {addr_strap_high_i, addr_strap_low_i};
    d.strap_s2 = q.strap_s1;
    d.own      = {ADDR_FIXED_BITS, q.strap_s2};
    if (led_index_i < LED_COUNT[7:0]) begin
      d.pwm_o   = q.regs.pwm[led_index_i];
      d.scale_o = q.regs.scale[led_index_i];
    end else begin
      d.pwm_o   = 8'h00;
      d.scale_o = 8'h00;
    end
    if (start_seen) begin // also a repeated start
      d.st       = DS_RX;
      d.cnt      = 4'h0;
      d.byte_no  = 2'h0;
      d.sda_oe_n = 1'b1;
    end else if (stop_seen) begin
      d.st       = DS_IDLE;
      d.sda_oe_n = 1'b1;
    end else begin
      unique case (q.st)
        DS_IDLE: begin
          d.sda_oe_n = 1'b1;
        end
        DS_RX: begin
          if (scl_rise) begin
            d.sh  = {q.sh[6:0], q.sda_s[1]};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == 4'h8) begin
            d.cnt      = 4'h0;
            d.st       = DS_ACK;
            d.sda_oe_n = 1'b0;
            if (q.byte_no == 2'h0) begin
              if (q.sh[7:1] == q.own) begin
                d.rd      = q.sh[0];
                d.byte_no = 2'h1;
              end else begin
                d.st       = DS_IDLE;
                d.sda_oe_n = 1'b1;
              end
            end else if (q.byte_no == 2'h1) begin
              d.ptr     = q.sh;
              d.byte_no = 2'h2;
            end else begin
              d.regs = wr_byte(q.regs, q.ptr, q.sh);
              d.ptr  = q.ptr + 8'h01;
            end
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            d.cnt = 4'h0;
            if (q.rd) begin
              d.st       = DS_TX;
              d.sh       = rd_byte(q.regs, q.ptr, q.own);
              d.sda_oe_n = d.sh[7];
            end else begin
              d.st       = DS_RX;
              d.sda_oe_n = 1'b1;
            end
          end
        end
        DS_TX: begin
          if (scl_fall) begin
            if (q.cnt == 4'h7) begin
              d.st       = DS_MACK;
              d.sda_oe_n = 1'b1;
            end else begin
              d.sh       = {q.sh[6:0], 1'b0};
              d.cnt      = q.cnt + 4'h1;
              d.sda_oe_n = q.sh[6];
            end
          end
        end
        DS_MACK: begin
          if (scl_rise) begin
            d.mack = ~q.sda_s[1];
          end else if (scl_fall) begin
            if (q.mack) begin
              d.ptr      = q.ptr + 8'h01;
              d.sh       = rd_byte(q.regs, q.ptr + 8'h01, q.own);
              d.sda_oe_n = d.sh[7];
              d.cnt      = 4'h0;
              d.st       = DS_TX;
            end else begin
              d.st = DS_IDLE; // master ended the read
            end
          end
        end
        default: begin
          d.st       = DS_IDLE;
          d.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign link.dev_sda_o     = 1'b0;
  assign link.dev_sda_oe_n  = q.sda_oe_n;
  assign pwm_duty_o         = q.pwm_o;
  assign current_scale_o    = q.scale_o;
  assign page_o             = q.regs.page;
  assign operating_config_o = q.regs.cfg;
  assign global_current_o   = q.regs.gcc;
  assign resistor_select_o  = q.regs.res;
  assign spread_spectrum_o  = q.regs.spread;

endmodule

/* File: rtl/led_i2c_host.sv */
// byte-level serial link master with an avalon command port
`timescale 1ns/10ps
module led_i2c_host
  import led_i2c_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // serial link
  i2c_link_if.host         link
);

  host_t q;
  host_t d;
  logic  busy;
  logic  cmd_wr;
  logic  step;

  assign busy   = (q.st != HS_IDLE);
  assign cmd_wr = avs_write_i & (avs_address_i == HOST_CMD_OFS);
  assign step   = (q.tick == 8'(SCL_QUARTER_CYC - 1));

  // commands stall while a byte is in flight, reads take one wait cycle
  assign avs_waitrequest_o = (avs_read_i & ~q.rvalid) | (cmd_wr & busy);

  // next state
  always_comb begin
    d        = q;
    d.sda_s1 = link.sda;
    d.sda_s2 = q.sda_s1;
    d.tick   = step ? 8'h00 : q.tick + 8'h01;
    // register read answer
    if (avs_read_i && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata  = 32'h0;
      if (avs_address_i == HOST_STAT_OFS) begin
        d.rdata = {16'h0, q.rx_byte, 6'h0, q.acked, busy};
      end
    end else begin
      d.rvalid = 1'b0;
    end
    unique case (q.st)
      HS_IDLE: begin
        if (cmd_wr) begin
          d.st         = avs_writedata_i[CMD_START_BIT] ? HS_START : HS_BITS;
          d.tick       = 8'h00;
          d.ph         = 2'h0;
          d.bitn       = 4'h0;
          d.stop_after = avs_writedata_i[CMD_STOP_BIT];
          d.is_read    = avs_writedata_i[CMD_READ_BIT];
          d.tx         = avs_writedata_i[CMD_READ_BIT] ? {8'hff, avs_writedata_i[CMD_NACK_BIT]}
                                                       : {avs_writedata_i[7:0], 1'b1};
        end
      end
      HS_START: begin
        if (step) begin
          d.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0: d.sda_oe_n = 1'b1;
            2'h1: d.scl      = 1'b1;
            2'h2: d.sda_oe_n = 1'b0;
            default: begin
              d.scl = 1'b0;
              d.st  = HS_BITS;
            end
          endcase
        end
      end
      HS_BITS: begin
        if (step) begin
          d.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0: d.sda_oe_n = q.tx[8]; // changes only while clock low
            2'h1: d.scl      = 1'b1;
            2'h2: d.rx       = {q.rx[7:0], q.sda_s2};
            default: begin
              d.scl  = 1'b0;
              d.tx   = {q.tx[7:0], 1'b1};
              d.bitn = q.bitn + 4'h1;
              if (q.bitn == 4'h8) begin
                d.acked   = ~q.rx[0];
                d.rx_byte = q.rx[8:1];
                d.bitn    = 4'h0;
                if (q.stop_after || (!q.is_read && q.rx[0])) begin
                  d.st = HS_STOP;
                end else begin
                  d.st = HS_IDLE;
                end
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (step) begin
          d.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0: d.sda_oe_n = 1'b0;
            2'h1: d.scl      = 1'b1;
            2'h2: d.sda_oe_n = 1'b1;
            default: d.st    = HS_IDLE;
          endcase
        end
      end
      default: d = HOST_RST;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign avs_readdata_o     = q.rdata;
  assign link.scl           = q.scl;
  assign link.host_sda_o    = 1'b0;
  assign link.host_sda_oe_n = q.sda_oe_n;

endmodule

/* File: testbench/led_i2c_link_checker.sv */
// link checker watching both ends of the two-wire link
`timescale 1ns/10ps
module led_i2c_link_checker (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // link wires
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       first_q;
  logic [3:0] bits_q;
  logic       rise;
  logic       start_ev;
  logic       stop_ev;
  logic       ack9;

  // edge and condition detection on the wires
  assign rise     = scl & ~scl_q;
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev  = scl & scl_q & ~sda_q & sda;
  assign ack9     = rise & (bits_q == 4'h8) & first_q;

  // count clock rises within each byte since the last start
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      first_q <= 1'b0;
      bits_q  <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev) begin
        first_q <= 1'b1;
        bits_q  <= 4'h0;
      end else if (rise) begin
        bits_q <= (bits_q == 4'h8) ? 4'h0 : bits_q + 4'h1;
        if (bits_q == 4'h8) begin
          first_q <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  // multi-cycle shapes of the link
  sequence s_scl_hold;
    scl [*8];
  endsequence
  sequence s_bus_idle;
    (scl && sda) [*8];
  endsequence
  sequence s_start_hold;
    (!sda) [*8];
  endsequence

  scl_hold_a: assert property ($rose(scl) |=> s_scl_hold)
    else $error("clock high phase too short");
  dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device moved data while clock high");
  start_hold_a: assert property (start_ev |=> s_start_hold)
    else $error("start not held");
  stop_idle_a: assert property (stop_ev |=> s_bus_idle)
    else $error("bus not idle after stop");
  addr_free_a: assert property (rise && first_q && bits_q < 4'h8 |-> dev_sda_oe_n)
    else $error("device drove during address bits");
  ack_release_a: assert property (ack9 |-> host_sda_oe_n)
    else $error("host held data in acknowledge slot");
  nack_stop_a: assert property (ack9 && sda |-> ##[1:500] stop_ev)
    else $error("no stop after missing acknowledge");
  stop_bound_a: assert property (stop_ev |-> bits_q == 4'h1)
    else $error("stop inside a byte");
endmodule

/* File: testbench/paged_led_driver_i2c_slave_tb_top.sv */
// bench joining host and led driver over the link, driven through avalon
`timescale 1ns/10ps
module paged_led_driver_i2c_slave_tb_top
  import led_i2c_pkg::*;
;
  typedef struct packed {
    logic [2:0]  sel;
    logic [15:0] mask;
    logic [15:0] exp;
  } note_t;
  localparam logic [3:0] ST = 4'h1;
  localparam logic [3:0] SP = 4'h2;
  localparam logic [3:0] RN = 4'hc;
  localparam logic [3:0] RD = 4'h4;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [1:0]  addr_strap_low_i = 2'h0;
  logic [1:0]  addr_strap_high_i = 2'h0;
  logic [7:0]  led_index_i = 8'h00;
  logic [7:0]  pwm_duty_o, current_scale_o, page_o, operating_config_o;
  logic [7:0]  global_current_o, resistor_select_o, spread_spectrum_o;
  note_t       notes[$];
  logic        look = 1'b0;
  int          n_errors = 0;
  int          compares = 0;
  int          seed = 32'h92c8;
  int          cycles = 0;
  logic [6:0]  own;
  logic [31:0] rd;
  logic [7:0]  v0, v1, v2, k;
  string       nm[8] = '{"status", "page", "config", "gcc", "resistor", "spread", "pwm", "scale"};

  always #10 clk_sys_i = ~clk_sys_i;

  // design ends, link and checker
  i2c_link_if i2c_link_if_inst ();
  led_i2c_host led_i2c_host_inst (.clk_sys_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .link(i2c_link_if_inst));
  led_i2c_device led_i2c_device_inst (.clk_sys_i, .reset_i, .link(i2c_link_if_inst), .addr_strap_low_i,
    .addr_strap_high_i, .led_index_i, .pwm_duty_o, .current_scale_o, .page_o, .operating_config_o,
    .global_current_o, .resistor_select_o, .spread_spectrum_o);
  led_i2c_link_checker led_i2c_link_checker_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .scl(i2c_link_if_inst.scl), .host_sda_o(i2c_link_if_inst.host_sda_o),
    .host_sda_oe_n(i2c_link_if_inst.host_sda_oe_n), .dev_sda_o(i2c_link_if_inst.dev_sda_o),
    .dev_sda_oe_n(i2c_link_if_inst.dev_sda_oe_n), .sda(i2c_link_if_inst.sda));

  // compare the oldest note with what a checked read shows
  always @(negedge clk_sys_i) begin
    note_t       n;
    logic [15:0] seen;
    if (avs_read_i && !avs_waitrequest_o && look) begin
      n = notes.pop_front();
      case (n.sel)
        3'h0: seen = avs_readdata_o[15:0];
        3'h1: seen = {8'h00, page_o};
        3'h2: seen = {8'h00, operating_config_o};
        3'h3: seen = {8'h00, global_current_o};
        3'h4: seen = {8'h00, resistor_select_o};
        3'h5: seen = {8'h00, spread_spectrum_o};
        3'h6: seen = {8'h00, pwm_duty_o};
        default: seen = {8'h00, current_scale_o};
      endcase
      compares++;
      if ((seen & n.mask) !== n.exp) begin
        n_errors++;
        $display("[FAIL] %s expected %h seen %h", nm[n.sel], n.exp, seen & n.mask);
      end
    end
  end

  // hang guard
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd, input logic chk);
    logic done;
    done = 1'b0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= wd;
    look <= chk;
    // waitrequest and read data are taken at the rising edge only
    while (!done) begin
      @(posedge clk_sys_i);
      done = (avs_waitrequest_o === 1'b0);
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    look <= 1'b0;
  endtask

  // one link byte, wait for idle, then note and check the status
  task automatic cmd(input logic [7:0] b, input logic [3:0] fl, input logic [15:0] m, input logic [15:0] e);
    av(1'b1, HOST_CMD_OFS, {20'h0, fl, b}, 1'b0);
    rd = 32'h1;
    while (rd[0] !== 1'b0) av(1'b0, HOST_STAT_OFS, 32'h0, 1'b0);
    notes.push_back('{3'h0, m, e});
    av(1'b0, HOST_STAT_OFS, 32'h0, 1'b1);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    cmd({own, 1'b0}, ST, 16'h2, 16'h2);
    cmd(p, 4'h0, 16'h2, 16'h2);
    cmd(d, SP, 16'h2, 16'h2);
  endtask

  task automatic rdreg(input logic [7:0] p, input logic [7:0] e);
    cmd({own, 1'b0}, ST, 16'h2, 16'h2);
    cmd(p, 4'h0, 16'h2, 16'h2);
    cmd({own, 1'b1}, ST, 16'h2, 16'h2);
    cmd(8'hff, RN | SP, 16'hff00, {e, 8'h00});
  endtask

  task automatic dev(input logic [2:0] s, input logic [7:0] e);
    notes.push_back('{s, 16'h00ff, {8'h00, e}});
    av(1'b0, HOST_STAT_OFS, 32'h0, 1'b1);
  endtask

  // main sequence
  initial begin
    own = {ADDR_FIXED_BITS, 4'($random(seed))};
    v0 = 8'($random(seed));
    v1 = 8'($random(seed));
    v2 = 8'($random(seed));
    k = 8'($unsigned($random(seed)) % LED_COUNT);
    // straps driven on the clock edge, reset held for three edges
    @(posedge clk_sys_i);
    addr_strap_low_i <= own[1:0];
    addr_strap_high_i <= own[3:2];
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    dev(3'h1, PWM_PAGE);
    rdreg(REG_ID, {own, 1'b0});
    wr(REG_PAGE, SCALING_PAGE);
    dev(3'h1, PWM_PAGE);
    wr(REG_UNLOCK, UNLOCK_KEY);
    wr(REG_PAGE, FUNCTION_PAGE);
    dev(3'h1, FUNCTION_PAGE);
    rdreg(REG_UNLOCK, 8'h00);
    wr(REG_PAGE, SCALING_PAGE);
    dev(3'h1, FUNCTION_PAGE);
    cmd({own, 1'b0}, ST, 16'h2, 16'h2);
    cmd(REG_CFG, 4'h0, 16'h2, 16'h2);
    cmd(v0, 4'h0, 16'h2, 16'h2);
    cmd(v1, 4'h0, 16'h2, 16'h2);
    cmd(v2, SP, 16'h2, 16'h2);
    dev(3'h2, v0);
    dev(3'h3, v1);
    dev(3'h4, v2);
    wr(REG_SPREAD, v1);
    dev(3'h5, v1);
    rdreg(REG_GCC, v1);
    // two-byte read, master acknowledges the first, pointer moves on
    cmd({own, 1'b0}, ST, 16'h2, 16'h2);
    cmd(REG_CFG, 4'h0, 16'h2, 16'h2);
    cmd({own, 1'b1}, ST, 16'h2, 16'h2);
    cmd(8'hff, RD, 16'hff02, {v0, 8'h02});
    cmd(8'hff, RN | SP, 16'hff00, {v1, 8'h00});
    wr(REG_SOFT_RESET, 8'h00);
    dev(3'h1, PWM_PAGE);
    dev(3'h3, 8'h00);
    dev(3'h4, RES_RST);
    dev(3'h5, 8'h00);
    led_index_i <= k;
    wr(k + 8'h01, v0);
    wr(REG_UNLOCK, UNLOCK_KEY);
    wr(REG_PAGE, SCALING_PAGE);
    wr(k + 8'h01, v2);
    dev(3'h6, v0);
    dev(3'h7, v2);
    cmd({own ^ 7'h01, 1'b0}, ST, 16'h2, 16'h0);
    rdreg(REG_ID, {own, 1'b0});
    print_verdict();
  end
endmodule
